// [dv/cisa_apb_model.sv]
/*
 * Software-side APB master standing in for the fetch stage and register loader.
 * Assumes one clock, pready sampled at rising edges, a bench that checks the ok flag.
 */
`timescale 1ns/1ns
module cisa_apb_model (
	// Clock
	input  wire logic        pclk,
	// APB master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// ----------------------------------------------------------------
	// One transfer: setup, access until pready, then release
	// ----------------------------------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err, output logic ok);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		ok = pready;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data must not look like the last value
		pwdata <= ~d;
		paddr <= ~a;
		pwrite <= ~w;
	endtask
endmodule

// [dv/cisa_decoder_asserts.sv]
/*
 * Port checker for the compact instruction decoder, bound to its top module.
 * Assumes one APB wait state and at most five execution cycles per instruction.
 */
`timescale 1ns/1ns
module cisa_decoder_asserts (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Core state
	input wire logic        exec_busy,
	input wire logic        compact_state
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic wr_done;
	logic mapped;
	assign wr_done = psel && penable && pready && pwrite;
	assign mapped = (paddr <= 8'h14 || (paddr >= 8'h40 && paddr <= 8'h7C)) && paddr[1:0] == 2'b00;

	// ----------------------------------------------------------------
	// Bus
	// ----------------------------------------------------------------
	ready_after_access_a: assert property ($rose(psel && penable) |=> pready)
		else $error("pready late");
	ready_one_cycle_a: assert property (pready |=> !pready) else $error("pready held");
	ready_needs_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	map_error_a: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == !mapped)
		else $error("wrong slave error");
	rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("stale read data");

	// ----------------------------------------------------------------
	// Execution
	// ----------------------------------------------------------------
	start_busy_a: assert property (
		$rose(exec_busy) |-> $past(wr_done && paddr == 8'h00 && pwdata[0])) else $error("busy without start");
	busy_bound_a: assert property (
		$rose(exec_busy) |-> ##[1:5] !exec_busy) else $error("busy too long");
	state_cause_a: assert property (
		$changed(compact_state) |-> $fell(exec_busy) || $past(wr_done && paddr == 8'h0C))
		else $error("state changed without cause");

	cover property ($fell(exec_busy) && !compact_state);
	cover property (pslverr);
	cover property ($rose(exec_busy) ##1 exec_busy ##1 exec_busy);
endmodule

bind cisa_decoder cisa_decoder_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.exec_busy(exec_busy), .compact_state(compact_state));

// [dv/cisa_decoder_tb_top.sv]
/*
 * Self-checking bench: loads registers and instructions over APB and checks results.
 * Assumes the decoder's register map, one APB wait state and its execution latencies.
 */
`timescale 1ns/1ns
module cisa_decoder_tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        pready;
	logic        pslverr;
	logic        exec_busy;
	logic        compact_state;
	logic        ok;
	logic        perr;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rv;
	int          err_count;
	int          n_checks;
	int          busy_cnt;

	// Two-register results with d=8000_00F3, s=4, carry set
	localparam logic [31:0] ALU_RES [16] = '{32'h0000_0000, 32'h8000_00F7, 32'h0000_0F30, 32'h0800_000F,
		32'hF800_000F, 32'h8000_00F8, 32'h8000_00EF, 32'h3800_000F, 32'h0000_0000, 32'hFFFF_FFFC,
		32'h8000_00EF, 32'h8000_00F7, 32'h8000_00F7, 32'h0000_03CC, 32'h8000_00F3, 32'hFFFF_FFFB};
	localparam logic [15:0] ALU_WR = 16'hF2FF;
	localparam logic [15:0] ALU_CYC2 = 16'h209C;

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	cisa_decoder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.exec_busy(exec_busy), .compact_state(compact_state));
	cisa_apb_model BFM (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	always @(posedge pclk) begin
		if (exec_busy === 1'b1) busy_cnt++;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		if (err_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
		BFM.xfer(w, a, d, rv, perr, ok);
		if (ok !== 1'b1) begin
			chk(32'h0000_0000, 32'h0000_0001);
			close_out();
		end
		chk({31'h0, perr}, {31'h0, e});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000, 1'b0);
		chk(rv, exp);
	endtask

	// Loads and starts one instruction, then counts busy cycles
	task automatic run(input logic [15:0] ins, input logic [2:0] cyc);
		int n;
		n = 0;
		xfer(1'b1, 8'h04, {16'h0000, ins}, 1'b0);
		busy_cnt = 0;
		xfer(1'b1, 8'h00, 32'h0000_0001, 1'b0);
		do begin
			@(posedge pclk);
			n++;
		end while (exec_busy !== 1'b0 && n < 50);
		if (n >= 50) begin
			chk(32'h0000_0000, 32'h0000_0001);
			close_out();
		end
		chk(32'(busy_cnt), {29'h0, cyc});
	endtask

	// ----------------------------------------------------------------
	// Sequence; never issues both-clear high add/compare/move ops, a state branch with the destination high flag, or one via r15
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		err_count = 0;
		n_checks = 0;
		busy_cnt = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h0C, 32'h0000_0020);
		chk({31'h0, compact_state}, 32'h0000_0001);
		xfer(1'b0, 8'h20, 32'h0000_0000, 1'b1);
		chk(rv, 32'h0000_0000);
		run(16'h2080, 3'h1);
		rd(8'h40, 32'h0000_0080);
		rd(8'h0C, 32'h0000_0020);
		run(16'h2880, 3'h1);
		rd(8'h40, 32'h0000_0080);
		rd(8'h0C, 32'h6000_0020);
		xfer(1'b1, 8'h44, 32'hFFFF_FFF1, 1'b0);
		run(16'h31FF, 3'h1);
		rd(8'h44, 32'h0000_00F0);
		rd(8'h0C, 32'h2000_0020);
		xfer(1'b1, 8'h44, 32'h7FFF_FFFF, 1'b0);
		run(16'h3101, 3'h1);
		rd(8'h44, 32'h8000_0000);
		rd(8'h0C, 32'h9000_0020);
		xfer(1'b1, 8'h58, 32'h0000_0010, 1'b0);
		run(16'h3E91, 3'h1);
		rd(8'h58, 32'hFFFF_FF7F);
		rd(8'h0C, 32'h8000_0020);
		for (int op = 0; op < 16; op++) begin
			xfer(1'b1, 8'h48, 32'h8000_00F3, 1'b0);
			xfer(1'b1, 8'h4C, 32'h0000_0004, 1'b0);
			xfer(1'b1, 8'h0C, 32'h2000_0020, 1'b0);
			run({6'b010000, 4'(op), 6'b011010}, ALU_CYC2[op] ? 3'h2 : 3'h1);
			rd(8'h48, ALU_WR[op] ? ALU_RES[op] : 32'h8000_00F3);
			xfer(1'b0, 8'h0C, 32'h0000_0000, 1'b0);
			chk(rv & 32'hC000_0020, {ALU_RES[op][31], ALU_RES[op] == 32'h0, 24'h0, 6'h20});
		end
		xfer(1'b1, 8'h0C, 32'hF000_0020, 1'b0);
		run(16'h4699, 3'h1);
		rd(8'h64, 32'h0000_0004);
		xfer(1'b1, 8'h48, 32'h0000_0010, 1'b0);
		run(16'h444A, 3'h1);
		rd(8'h48, 32'h0000_0014);
		rd(8'h0C, 32'hF000_0020);
		run(16'h4599, 3'h1);
		rd(8'h0C, 32'h6000_0020);
		xfer(1'b1, 8'h08, 32'h0000_0103, 1'b0);
		run(16'h4678, 3'h1);
		rd(8'h40, 32'h0000_0106);
		xfer(1'b1, 8'h68, 32'h0000_3001, 1'b0);
		run(16'h4750, 3'h3);
		rd(8'h08, 32'h0000_3000);
		rd(8'h10, 32'h0000_0002);
		chk({31'h0, compact_state}, 32'h0000_0001);
		xfer(1'b1, 8'h50, 32'h0000_2000, 1'b0);
		run(16'h4720, 3'h3);
		chk({31'h0, compact_state}, 32'h0000_0000);
		rd(8'h08, 32'h0000_2000);
		run(16'h2005, 3'h1);
		rd(8'h10, 32'h0000_0004);
		rd(8'h40, 32'h0000_0106);
		close_out();
	end
endmodule

// [hw/cisa_decoder.sv]
/*
 * Decode and execute of three compact instruction groups: immediate
 * move/compare/add/subtract, two-register ALU operations, and high
 * register add/compare/move with the register-indirect state branch.
 * Assumes an APB master on pclk; software loads the instruction and its
 * address, then writes the start bit.
 */
// Overview of operation
// RULE1: Op 00 moves zero-extended immediate, sets flags
// RULE2: Op 01 compares register with immediate only
// RULE3: Op 10 adds immediate back into register
// RULE4: Op 11 subtracts immediate back into register
// RULE5: Immediate and ALU groups always update flags
// RULE6: AND, XOR, OR, bit clear, move inverted
// RULE7: Register-amount shifts and rotate on destination
// RULE8: Add with carry, subtract with borrow
// RULE9: Test, compare, compare negated: flags only
// RULE10: Negate source; multiply into destination
// RULE11: High group fields; high flag adds eight
// RULE12: High add and move across all sixteen
// RULE13: High group sets flags only on compare
// RULE14: Stream avoids high ops with flags clear
// RULE15: Opcode 11 branches to source register
// RULE16: Target bit 0 picks the instruction state
// RULE17: Stream avoids destination flag on branch
// RULE18: Register 15 reads as address+4, bit0 clear
// RULE19: No branch via register 15 unaligned
// RULE20: Cycles equal the 32-bit equivalent
// RULE21: N, Z from result; arithmetic sets C, V
`timescale 1ns/1ns
`include "cisa_cfg.svh"

module cisa_decoder
	import cisa_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Core state
	output logic             exec_busy,
	output logic             compact_state
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [31:0]  gpr_q [15];
	logic [31:0]  pc_q;
	logic [15:0]  instr_q;
	cisa_flags_t  flags_q;
	logic         compact_q;
	logic         branched_q;
	logic         rejected_q;
	logic [31:0]  target_q;
	cisa_state_t  state_q;
	logic [2:0]   cnt_q;
	cisa_result_t pend_q;
	logic [31:0]  prdata_q;
	logic         pready_q;
	logic         pslverr_q;
	logic         busy_q;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Register 15 reads as the pipelined address with bit 0 forced low
	function automatic logic [31:0] rd_op(input logic [3:0] idx);
		if (idx == 4'hF) begin
			rd_op = (pc_q + `CISA_PC_AHEAD) & ~32'h0000_0001; // see RULE18
		end else begin
			rd_op = gpr_q[idx];
		end
	endfunction

	// Returns {v, c, sum}; subtraction passes the inverted operand
	function automatic logic [33:0] adder(input logic [31:0] a, input logic [31:0] b, input logic cin);
		logic [32:0] s;
		s = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
		adder = {(a[31] == b[31]) && (s[31] != a[31]), s};
	endfunction

	// Flags of an arithmetic result, all four updated
	function automatic cisa_flags_t arith_flags(input logic [33:0] r);
		arith_flags = '{n: r[31], z: (r[31:0] == 32'h0000_0000), c: r[32], v: r[33]}; // see RULE21
	endfunction

	// Flags of a logical result: carry given, overflow kept
	function automatic cisa_flags_t logic_flags(input logic [31:0] r, input logic c, input logic v);
		logic_flags = '{n: r[31], z: (r == 32'h0000_0000), c: c, v: v}; // see RULE21
	endfunction

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	logic apb_take;
	logic apb_wr;
	logic addr_gpr;
	logic addr_ok;
	logic start_req;
	logic [3:0] apb_gidx;

	assign apb_take  = psel && penable && pready_q;
	assign apb_wr    = apb_take && pwrite && !pslverr_q;
	assign addr_gpr  = (paddr >= `CISA_OFF_GPR_BASE) && (paddr <= `CISA_OFF_GPR_LAST) && (paddr[1:0] == 2'b00);
	assign apb_gidx  = paddr[5:2];
	assign addr_ok   = addr_gpr || (paddr == `CISA_OFF_CTRL) || (paddr == `CISA_OFF_INSTR) ||
	                   (paddr == `CISA_OFF_PC) || (paddr == `CISA_OFF_PSW) ||
	                   (paddr == `CISA_OFF_STATUS) || (paddr == `CISA_OFF_TARGET);
	assign start_req = apb_wr && (paddr == `CISA_OFF_CTRL) && pwdata[`CISA_CTRL_START] && (state_q == CISA_IDLE);

	// ------------------------------------------------------------------
	// Decode and compute
	// ------------------------------------------------------------------
	cisa_result_t res;
	logic [2:0]  rd_lo;
	logic [2:0]  src_lo;
	logic [3:0]  dst_idx;
	logic [3:0]  src_idx;
	logic [31:0] opd;
	logic [31:0] ops;
	logic [31:0] imm;
	logic [7:0]  amt;
	logic [63:0] sh;
	logic [33:0] sum;
	logic [31:0] prod;

	always_comb begin
		res          = '0;
		res.flags    = flags_q;
		res.compact  = compact_q;
		res.cycles   = `CISA_CYC_PLAIN;
		res.target   = pc_q + `CISA_PC_STEP;
		rd_lo        = instr_q[2:0];
		src_lo       = instr_q[5:3];
		dst_idx      = {instr_q[7], instr_q[2:0]}; // see RULE11
		src_idx      = {instr_q[6], instr_q[5:3]}; // see RULE11
		opd          = 32'h0000_0000;
		ops          = 32'h0000_0000;
		imm          = {24'h00_0000, instr_q[7:0]};
		amt          = 8'h00;
		sh           = 64'h0000_0000_0000_0000;
		sum          = 34'h0_0000_0000;
		prod         = 32'h0000_0000;
		if (!compact_q) begin
			res.reject = 1'b1;
		end else if (instr_q[15:13] == 3'b001) begin
			opd          = rd_op({1'b0, instr_q[10:8]});
			res.reg_idx  = {1'b0, instr_q[10:8]};
			res.flags_we = 1'b1; // see RULE5
			unique case (instr_q[12:11])
				2'b00: begin
					res.reg_we  = 1'b1;
					res.reg_val = imm; // see RULE1
					res.flags   = logic_flags(imm, flags_q.c, flags_q.v);
				end
				2'b01: begin
					sum       = adder(opd, ~imm, 1'b1); // see RULE2
					res.flags = arith_flags(sum);
				end
				2'b10: begin
					sum         = adder(opd, imm, 1'b0); // see RULE3
					res.reg_we  = 1'b1;
					res.reg_val = sum[31:0];
					res.flags   = arith_flags(sum);
				end
				2'b11: begin
					sum         = adder(opd, ~imm, 1'b1); // see RULE4
					res.reg_we  = 1'b1;
					res.reg_val = sum[31:0];
					res.flags   = arith_flags(sum);
				end
			endcase
		end else if (instr_q[15:10] == 6'b010000) begin
			opd          = rd_op({1'b0, rd_lo});
			ops          = rd_op({1'b0, src_lo});
			amt          = ops[7:0];
			prod         = ops * opd;
			res.reg_idx  = {1'b0, rd_lo};
			res.reg_we   = 1'b1;
			res.flags_we = 1'b1; // see RULE5
			unique case (instr_q[9:6])
				4'b0000: res.reg_val = opd & ops; // see RULE6
				4'b0001: res.reg_val = opd ^ ops; // see RULE6
				4'b1100: res.reg_val = opd | ops; // see RULE6
				4'b1110: res.reg_val = opd & ~ops; // see RULE6
				4'b1111: res.reg_val = ~ops; // see RULE6
				4'b0101: begin
					sum         = adder(opd, ops, flags_q.c); // see RULE8
					res.reg_val = sum[31:0];
				end
				4'b0110: begin
					sum         = adder(opd, ~ops, flags_q.c); // see RULE8
					res.reg_val = sum[31:0];
				end
				4'b1001: begin
					sum         = adder(32'h0000_0000, ~ops, 1'b1); // see RULE10
					res.reg_val = sum[31:0];
				end
				4'b1101: begin
					res.reg_val = prod; // see RULE10
					// Early termination on the multiplier's sign bytes
					if (ops[31:8] == 24'h00_0000 || ops[31:8] == 24'hFF_FFFF) begin
						res.cycles = `CISA_CYC_MPY_BASE + 3'h1; // see RULE20
					end else if (ops[31:16] == 16'h0000 || ops[31:16] == 16'hFFFF) begin
						res.cycles = `CISA_CYC_MPY_BASE + 3'h2;
					end else if (ops[31:24] == 8'h00 || ops[31:24] == 8'hFF) begin
						res.cycles = `CISA_CYC_MPY_BASE + 3'h3;
					end else begin
						res.cycles = `CISA_CYC_MPY_BASE + 3'h4;
					end
				end
				4'b1000: begin
					res.reg_we  = 1'b0; // see RULE9
					res.reg_val = opd & ops;
				end
				4'b1010: begin
					res.reg_we = 1'b0;
					sum        = adder(opd, ~ops, 1'b1); // see RULE9
				end
				4'b1011: begin
					res.reg_we = 1'b0;
					sum        = adder(opd, ops, 1'b0); // see RULE9
				end
				4'b0010: begin
					// Amount 32 still shifts out bit 0 into carry
					sh          = {32'h0000_0000, opd} << amt[5:0]; // see RULE7
					res.reg_val = (amt > 8'd32) ? 32'h0000_0000 : sh[31:0];
					res.cycles  = `CISA_CYC_REGSHIFT; // see RULE20
				end
				4'b0011: begin
					sh          = {opd, 32'h0000_0000} >> amt[5:0]; // see RULE7
					res.reg_val = (amt > 8'd32) ? 32'h0000_0000 : sh[63:32];
					res.cycles  = `CISA_CYC_REGSHIFT;
				end
				4'b0100: begin
					sh          = $signed({opd, 32'h0000_0000}) >>> ((amt > 8'd32) ? 6'd32 : amt[5:0]); // see RULE7
					res.reg_val = sh[63:32];
					res.cycles  = `CISA_CYC_REGSHIFT;
				end
				4'b0111: begin
					sh          = {opd, opd} >> amt[4:0]; // see RULE7
					res.reg_val = sh[31:0];
					res.cycles  = `CISA_CYC_REGSHIFT;
				end
			endcase
			// Flags per operation class
			unique case (instr_q[9:6])
				4'b0101, 4'b0110, 4'b1001, 4'b1010, 4'b1011: res.flags = arith_flags(sum);
				4'b1000: res.flags = logic_flags(opd & ops, flags_q.c, flags_q.v);
				4'b0010: res.flags = logic_flags(res.reg_val, (amt == 8'h00) ? flags_q.c :
					(amt > 8'd32) ? 1'b0 : sh[32], flags_q.v);
				4'b0011: res.flags = logic_flags(res.reg_val, (amt == 8'h00) ? flags_q.c :
					(amt > 8'd32) ? 1'b0 : sh[31], flags_q.v);
				4'b0100: res.flags = logic_flags(res.reg_val, (amt == 8'h00) ? flags_q.c :
					(amt > 8'd32) ? opd[31] : sh[31], flags_q.v);
				4'b0111: res.flags = logic_flags(res.reg_val, (amt == 8'h00) ? flags_q.c :
					res.reg_val[31], flags_q.v);
				default: res.flags = logic_flags(res.reg_val, flags_q.c, flags_q.v);
			endcase
		end else if (instr_q[15:10] == 6'b010001) begin
			opd         = rd_op(dst_idx);
			ops         = rd_op(src_idx);
			res.reg_idx = dst_idx;
			unique case (instr_q[9:8])
				2'b00: begin
					sum         = adder(opd, ops, 1'b0); // see RULE12
					res.reg_we  = 1'b1;
					res.reg_val = sum[31:0];
				end
				2'b01: begin
					sum          = adder(opd, ~ops, 1'b1);
					res.flags_we = 1'b1; // see RULE13
					res.flags    = arith_flags(sum);
				end
				2'b10: begin
					res.reg_we  = 1'b1;
					res.reg_val = ops; // see RULE12
				end
				2'b11: begin
					// Destination flag is ignored here; the stream must not set it
					res.branch  = 1'b1; // see RULE15
					res.target  = ops & ~32'h0000_0001;
					res.compact = ops[0]; // see RULE16
					res.cycles  = `CISA_CYC_BRANCH; // see RULE20
				end
			endcase
			// A write to register 15 is a branch that stays in this state
			if (res.reg_we && dst_idx == 4'hF) begin
				res.reg_we = 1'b0;
				res.branch = 1'b1;
				res.target = res.reg_val & ~32'h0000_0001;
				res.cycles = `CISA_CYC_BRANCH; // see RULE20
			end
		end else begin
			res.reject = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Execution sequencer
	// ------------------------------------------------------------------
	logic commit;
	assign commit = (state_q == CISA_EXEC) && (cnt_q == 3'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= CISA_IDLE;
			cnt_q   <= 3'h0;
			pend_q  <= '0;
		end else begin
			unique case (state_q)
				CISA_IDLE: begin
					if (start_req) begin
						state_q <= CISA_EXEC;
						cnt_q   <= res.reject ? 3'h1 : res.cycles; // see RULE20
						pend_q  <= res;
					end
				end
				CISA_EXEC: begin
					cnt_q <= cnt_q - 3'h1;
					if (commit) begin
						state_q <= CISA_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Architectural state; a commit wins over a same-cycle bus write
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 15; i++) begin
				gpr_q[i] <= 32'h0000_0000;
			end
		end else if (commit && !pend_q.reject && pend_q.reg_we) begin
			gpr_q[pend_q.reg_idx] <= pend_q.reg_val;
		end else if (apb_wr && addr_gpr && apb_gidx != 4'hF) begin
			gpr_q[apb_gidx] <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q      <= `CISA_RST_PC;
			compact_q <= `CISA_RST_COMPACT;
			flags_q   <= '0;
			target_q  <= 32'h0000_0000;
		end else if (commit && !pend_q.reject) begin
			pc_q      <= pend_q.target;
			compact_q <= pend_q.compact; // see RULE16
			if (pend_q.flags_we) begin
				flags_q <= pend_q.flags; // see RULE13
			end
			if (pend_q.branch) begin
				target_q <= pend_q.target;
			end
		end else if (apb_wr && (paddr == `CISA_OFF_PC || (addr_gpr && apb_gidx == 4'hF))) begin
			pc_q <= pwdata;
		end else if (apb_wr && paddr == `CISA_OFF_PSW) begin
			flags_q   <= {pwdata[`CISA_PSW_N], pwdata[`CISA_PSW_Z], pwdata[`CISA_PSW_C], pwdata[`CISA_PSW_V]};
			compact_q <= pwdata[`CISA_PSW_COMPACT];
		end
	end

	// Sticky outcome bits; a commit sets them over a clearing write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			branched_q <= 1'b0;
			rejected_q <= 1'b0;
		end else if (commit) begin
			branched_q <= pend_q.branch && !pend_q.reject;
			rejected_q <= pend_q.reject;
		end else if (start_req) begin
			branched_q <= 1'b0;
			rejected_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_q <= 16'h0000;
		end else if (apb_wr && paddr == `CISA_OFF_INSTR && state_q == CISA_IDLE) begin
			instr_q <= pwdata[15:0];
		end
	end

	// ------------------------------------------------------------------
	// APB answer: one wait state, error on unmapped addresses
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !addr_ok;
			prdata_q  <= 32'h0000_0000;
			if (psel && penable && !pready_q && !pwrite) begin
				if (addr_gpr) begin
					prdata_q <= (apb_gidx == 4'hF) ? pc_q : gpr_q[apb_gidx];
				end else begin
					unique case (paddr)
						`CISA_OFF_CTRL:   prdata_q <= {31'h0000_0000, state_q == CISA_EXEC};
						`CISA_OFF_INSTR:  prdata_q <= {16'h0000, instr_q};
						`CISA_OFF_PC:     prdata_q <= pc_q;
						`CISA_OFF_PSW:    prdata_q <= {flags_q, 22'h00_0000, compact_q, 5'h00};
						`CISA_OFF_STATUS: prdata_q <= {29'h0000_0000, rejected_q, branched_q, state_q == CISA_EXEC};
						`CISA_OFF_TARGET: prdata_q <= target_q;
						default:          prdata_q <= 32'h0000_0000;
					endcase
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= start_req || ((state_q == CISA_EXEC) && !commit);
		end
	end

	assign prdata        = prdata_q;
	assign pready        = pready_q;
	assign pslverr       = pslverr_q;
	assign exec_busy     = busy_q;
	assign compact_state = compact_q;

endmodule

// [shared/cisa_cfg.svh]
/*
 * Register map, field positions, reset values and cycle counts of the
 * compact instruction decoder. Assumes a 32-bit APB with byte addresses.
 */
`ifndef CISA_CFG_SVH
`define CISA_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CISA_OFF_CTRL      8'h00
`define CISA_OFF_INSTR     8'h04
`define CISA_OFF_PC        8'h08
`define CISA_OFF_PSW       8'h0C
`define CISA_OFF_STATUS    8'h10
`define CISA_OFF_TARGET    8'h14
`define CISA_OFF_GPR_BASE  8'h40
`define CISA_OFF_GPR_LAST  8'h7C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CISA_CTRL_START    0
`define CISA_PSW_N         31
`define CISA_PSW_Z         30
`define CISA_PSW_C         29
`define CISA_PSW_V         28
`define CISA_PSW_COMPACT   5
`define CISA_ST_BUSY       0
`define CISA_ST_BRANCHED   1
`define CISA_ST_REJECTED   2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CISA_RST_PC        32'h0000_0000
`define CISA_RST_COMPACT   1'b1

// ----------------------------------------------------------------------
// Cycle counts, matching the equivalent 32-bit instructions
// ----------------------------------------------------------------------
`define CISA_CYC_PLAIN     3'h1
`define CISA_CYC_REGSHIFT  3'h2
`define CISA_CYC_BRANCH    3'h3
`define CISA_CYC_MPY_BASE  3'h1
`define CISA_PC_AHEAD      32'h0000_0004
`define CISA_PC_STEP       32'h0000_0002

`endif

// [shared/cisa_pkg.sv]
/*
 * Types of the compact instruction decoder.
 * Assumes cisa_cfg.svh supplies every number.
 */
package cisa_pkg;

	// Condition flags as held in the program status word
	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} cisa_flags_t;

	// Execution sequencer
	typedef enum logic [0:0] {
		CISA_IDLE = 1'b0,
		CISA_EXEC = 1'b1
	} cisa_state_t;

	// Result of one decoded instruction, committed at its last cycle
	typedef struct packed {
		logic        reg_we;
		logic [3:0]  reg_idx;
		logic [31:0] reg_val;
		logic        flags_we;
		cisa_flags_t flags;
		logic        branch;
		logic [31:0] target;
		logic        compact;
		logic        reject;
		logic [2:0]  cycles;
	} cisa_result_t;

endpackage
